// *** hw/spfdp_pkg.sv ***
package spfdp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONFIG = 6'h01;
  localparam logic [5:0] IDX_IRQ_ENABLE_CONTROL = 6'h02;
  localparam logic [5:0] IDX_IRQ_FLAG_STATUS = 6'h03;
  localparam logic [5:0] IDX_SHIFT_DATA_PORT = 6'h04;
  // Config register fields
  localparam int CFG_BUFFERED_MODE_EN = 7;
  localparam int CFG_MASTER = 5;
  localparam int CFG_SLAVE_SELECT_IGNORE = 2;
  localparam int CFG_SS_PIN_INPUT = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Enable register fields
  localparam int EN_RX_COMPLETE = 7;
  localparam int EN_TX_COMPLETE = 6;
  localparam int EN_TX_EMPTY = 5;
  localparam int EN_SLAVE_SELECT = 4;
  localparam int EN_SINGLE = 0;
  localparam logic [7:0] EN_RESET = 8'h00;
  // Flag register fields
  localparam int FL_RX_COMPLETE = 7;
  localparam int FL_TX_COMPLETE = 6;
  localparam int FL_TX_EMPTY = 5;
  localparam int FL_SLAVE_SELECT = 4;
  localparam int FL_RX_OVERRUN = 0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Receive buffer depth in buffered mode
  localparam int RX_DEPTH = 2;

  typedef struct packed {
    logic xfer;       // Shared receive/transfer flag, non-buffered
    logic collision;  // Write collision, non-buffered
    logic tx_complete;
    logic tx_empty;
    logic slave_select;
    logic rx_overrun;
  } spfdp_flags_t;

  typedef enum logic [1:0] {
    SPFDP_TX_IDLE = 2'b00,
    SPFDP_TX_HELD = 2'b01
  } spfdp_tx_state_t;
endpackage

// *** hw/spfdp_core.sv ***
// Functional notes
// - Buffered: slave-select enable gates its interrupt; non-buffered it reads zero.
// - Non-buffered: single enable raises interrupt while combined flag set.
// - Buffered: receive-complete high while receive buffer holds unread data.
// - Buffered: receive-complete cleared by reading the last unread byte or writing one to it.
// - Non-buffered: transfer flag set when a byte finishes shifting.
// - Master with slave-select input driven low also sets transfer flag.
// - Transfer flag cleared by vector, or flag read then data access.
// - Buffered: transfer-complete set when shifter empties, nothing pending; write-one clears.
// - Non-buffered: data write during shifting sets collision; read-then-access clears.
// - Buffered: transmit-empty set when the buffered byte moves to the shifter; non-buffered reads zero.
// - Transmit-empty flag is zero after reset.
// - Writing data register clears transmit-empty flag.
// - Buffered: slave-select takeover of master sets flag unless ignored; write-one clears.
// - Buffered: overrun set when two-entry buffer full and third byte completes.
// - Without pending transmit data, overrun waits for next transfer start.
// - Overrun stays until software reads the data register.
// - Data write starts transmission; byte goes to the shifter.
// - Data read returns oldest received byte; rest advance.
// - Buffered mode: two receive stages, one transmit stage, separate flags.
// - Interrupt asserted while enable and flag set, until flag cleared.
//
// Local design decision: the address-and-strobe port.
module spfdp_core #(
  parameter int RX_DEPTH = spfdp_pkg::RX_DEPTH
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WRITE,
  input wire logic I_READ,
  output logic [7:0] O_RDATA,
  // Interrupt
  output logic O_IRQ,
  input wire logic I_IRQ_ACK,
  // Slave-select pin
  input wire logic I_SS_N,
  // Shift engine
  output logic O_SHIFT_LOAD,
  output logic [7:0] O_SHIFT_DATA,
  input wire logic I_SHIFT_BUSY,
  input wire logic I_SHIFT_START,
  input wire logic I_SHIFT_DONE,
  input wire logic [7:0] I_SHIFT_RDATA,
  // Status
  output logic O_MASTER
);
  logic [5:0] idx;
  logic acc_ok, wr_cfg, wr_en, wr_fl, wr_dat, rd_fl, rd_dat, dat_acc;
  logic [7:0] cfg_reg, en_reg, tx_buf_reg, shift_data_reg;
  logic tx_valid_reg, buf_mode, ss_n_meta_reg, ss_n_reg, takeover;
  logic load_now, arm_xfer_reg, arm_coll_reg, ovf_pend_reg, rx_wr1c;
  logic xfer_reg, coll_reg, txc_reg, txe_reg, ssf_reg, ovf_reg;
  spfdp_pkg::spfdp_flags_t flags_reg;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [1:0] rx_count_reg;
  logic rx_push, rx_pop, rx_full;
  logic [7:0] flag_view, en_view, rdata_next;

  // Register decode on word-aligned byte addresses
  assign idx = I_ADDR[7:2];
  assign acc_ok = (I_ADDR[1:0] == 2'b00);
  assign wr_cfg = I_WRITE && acc_ok && (idx == spfdp_pkg::IDX_CONFIG);
  assign wr_en = I_WRITE && acc_ok && (idx == spfdp_pkg::IDX_IRQ_ENABLE_CONTROL);
  assign wr_fl = I_WRITE && acc_ok && (idx == spfdp_pkg::IDX_IRQ_FLAG_STATUS);
  assign wr_dat = I_WRITE && acc_ok && (idx == spfdp_pkg::IDX_SHIFT_DATA_PORT);
  assign rd_fl = I_READ && acc_ok && (idx == spfdp_pkg::IDX_IRQ_FLAG_STATUS);
  assign rd_dat = I_READ && acc_ok && (idx == spfdp_pkg::IDX_SHIFT_DATA_PORT);
  assign dat_acc = wr_dat || rd_dat;
  assign buf_mode = cfg_reg[spfdp_pkg::CFG_BUFFERED_MODE_EN];
  assign O_MASTER = cfg_reg[spfdp_pkg::CFG_MASTER];
  // Each flag bit has its own register so that every bit has a single writer
  assign flags_reg = {xfer_reg, coll_reg, txc_reg, txe_reg, ssf_reg, ovf_reg};

  // Pin synchroniser; only the second stage is read
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ss_n_meta_reg <= 1'b1;
      ss_n_reg <= 1'b1;
    end else begin
      ss_n_meta_reg <= I_SS_N;
      ss_n_reg <= ss_n_meta_reg;
    end
  end

  // External low on slave-select pulls a master into slave
  assign takeover = cfg_reg[spfdp_pkg::CFG_MASTER] && cfg_reg[spfdp_pkg::CFG_SS_PIN_INPUT]
    && !cfg_reg[spfdp_pkg::CFG_SLAVE_SELECT_IGNORE] && !ss_n_reg;

  // Configuration; takeover wins over a write restoring master
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      cfg_reg <= spfdp_pkg::CFG_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= I_WDATA;
      end
      if (takeover) begin
        cfg_reg[spfdp_pkg::CFG_MASTER] <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      en_reg <= spfdp_pkg::EN_RESET;
    end else if (wr_en) begin
      en_reg <= I_WDATA;
    end
  end

  // Transmit path: buffered mode holds one byte ahead of the shifter
  assign load_now = buf_mode ? (tx_valid_reg && !I_SHIFT_BUSY)
                             : (wr_dat && !I_SHIFT_BUSY);

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      tx_buf_reg <= spfdp_pkg::DATA_RESET;
      tx_valid_reg <= 1'b0;
    end else if (!buf_mode) begin
      tx_valid_reg <= 1'b0;
    end else if (wr_dat) begin
      // A write into a full buffer replaces the waiting byte
      tx_buf_reg <= I_WDATA;
      tx_valid_reg <= 1'b1;
    end else if (load_now) begin
      tx_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_SHIFT_LOAD <= 1'b0;
      shift_data_reg <= spfdp_pkg::DATA_RESET;
    end else begin
      O_SHIFT_LOAD <= load_now;
      if (load_now) begin
        shift_data_reg <= buf_mode ? tx_buf_reg : I_WDATA;
      end
    end
  end
  assign O_SHIFT_DATA = shift_data_reg;

  // Receive FIFO; non-buffered mode keeps just the newest byte in entry 0
  assign rx_full = (rx_count_reg == 2'(RX_DEPTH));
  assign rx_wr1c = buf_mode && wr_fl && I_WDATA[spfdp_pkg::FL_RX_COMPLETE];
  assign rx_pop = buf_mode && rd_dat && (rx_count_reg != 2'h0);
  assign rx_push = buf_mode && I_SHIFT_DONE && (!rx_full || rx_pop);

  generate
    for (genvar g = 0; g < RX_DEPTH; g++) begin : g_rx
      always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
          rx_mem[g] <= spfdp_pkg::DATA_RESET;
        end else if (!buf_mode) begin
          if (g == 0 && I_SHIFT_DONE) begin
            rx_mem[g] <= I_SHIFT_RDATA;
          end
        end else if (rx_wr1c) begin
          if (g == 0 && I_SHIFT_DONE) begin
            rx_mem[g] <= I_SHIFT_RDATA;
          end
        end else if (rx_pop) begin
          // Oldest leaves, younger entries advance
          if (g + 1 < RX_DEPTH && 2'(g + 1) < rx_count_reg) begin
            rx_mem[g] <= rx_mem[(g + 1) % RX_DEPTH];
          end else if (rx_push && 2'(g + 1) == rx_count_reg) begin
            rx_mem[g] <= I_SHIFT_RDATA;
          end
        end else if (rx_push && 2'(g) == rx_count_reg) begin
          rx_mem[g] <= I_SHIFT_RDATA;
        end
      end
    end
  endgenerate

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      rx_count_reg <= 2'h0;
    end else if (!buf_mode) begin
      rx_count_reg <= 2'h0;
    end else if (rx_wr1c) begin
      // Writing one drops the unread bytes; a byte landing now survives
      rx_count_reg <= 2'(I_SHIFT_DONE);
    end else begin
      rx_count_reg <= rx_count_reg + 2'(rx_push) - 2'(rx_pop);
    end
  end

  // Clear by flag read then data access: the read arms, the access clears
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      arm_xfer_reg <= 1'b0;
      arm_coll_reg <= 1'b0;
    end else if (dat_acc) begin
      arm_xfer_reg <= 1'b0;
      arm_coll_reg <= 1'b0;
    end else if (rd_fl) begin
      arm_xfer_reg <= flags_reg.xfer;
      arm_coll_reg <= flags_reg.collision;
    end
  end

  // Non-buffered flags; a set in the clearing cycle wins
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      xfer_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else if (buf_mode) begin
      xfer_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else begin
      if (I_SHIFT_DONE || takeover) begin
        xfer_reg <= 1'b1;
      end else if (I_IRQ_ACK || (arm_xfer_reg && dat_acc)) begin
        xfer_reg <= 1'b0;
      end
      if (wr_dat && I_SHIFT_BUSY) begin
        coll_reg <= 1'b1;
      end else if (arm_coll_reg && dat_acc) begin
        coll_reg <= 1'b0;
      end
    end
  end

  // Buffered flags
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      txc_reg <= 1'b0;
      txe_reg <= 1'b0;
      ssf_reg <= 1'b0;
    end else if (!buf_mode) begin
      txc_reg <= 1'b0;
      txe_reg <= 1'b0;
      ssf_reg <= 1'b0;
    end else begin
      if (I_SHIFT_DONE && !tx_valid_reg && !wr_dat) begin
        txc_reg <= 1'b1;
      end else if (wr_fl && I_WDATA[spfdp_pkg::FL_TX_COMPLETE]) begin
        txc_reg <= 1'b0;
      end
      if (wr_dat) begin
        txe_reg <= 1'b0;
      end else if (load_now) begin
        txe_reg <= 1'b1;
      end
      if (takeover) begin
        ssf_reg <= 1'b1;
      end else if (wr_fl && I_WDATA[spfdp_pkg::FL_SLAVE_SELECT]) begin
        ssf_reg <= 1'b0;
      end
    end
  end

  // Overrun; with no transmit data queued it waits for the next start
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ovf_reg <= 1'b0;
      ovf_pend_reg <= 1'b0;
    end else if (!buf_mode) begin
      ovf_reg <= 1'b0;
      ovf_pend_reg <= 1'b0;
    end else begin
      if (I_SHIFT_DONE && rx_full && !rx_pop && !rx_wr1c && tx_valid_reg) begin
        ovf_reg <= 1'b1;
      end else if (ovf_pend_reg && I_SHIFT_START) begin
        ovf_reg <= 1'b1;
      end else if (rd_dat) begin
        ovf_reg <= 1'b0;
      end
      if (I_SHIFT_DONE && rx_full && !rx_pop && !rx_wr1c && !tx_valid_reg) begin
        ovf_pend_reg <= 1'b1;
      end else if (I_SHIFT_START || rd_dat) begin
        ovf_pend_reg <= 1'b0;
      end
    end
  end

  // Register views; in non-buffered mode the bits that mode does not use read zero
  always_comb begin
    flag_view = 8'h00;
    en_view = 8'h00;
    if (buf_mode) begin
      flag_view[spfdp_pkg::FL_RX_COMPLETE] = (rx_count_reg != 2'h0);
      flag_view[spfdp_pkg::FL_TX_COMPLETE] = flags_reg.tx_complete;
      flag_view[spfdp_pkg::FL_TX_EMPTY] = flags_reg.tx_empty;
      flag_view[spfdp_pkg::FL_SLAVE_SELECT] = flags_reg.slave_select;
      flag_view[spfdp_pkg::FL_RX_OVERRUN] = flags_reg.rx_overrun;
      en_view = en_reg;
    end else begin
      flag_view[spfdp_pkg::FL_RX_COMPLETE] = flags_reg.xfer;
      flag_view[spfdp_pkg::FL_TX_COMPLETE] = flags_reg.collision;
      en_view[spfdp_pkg::EN_SINGLE] = en_reg[spfdp_pkg::EN_SINGLE];
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (I_READ && acc_ok) begin
      case (idx)
        spfdp_pkg::IDX_CONFIG: rdata_next = cfg_reg;
        spfdp_pkg::IDX_IRQ_ENABLE_CONTROL: rdata_next = en_view;
        spfdp_pkg::IDX_IRQ_FLAG_STATUS: rdata_next = flag_view;
        spfdp_pkg::IDX_SHIFT_DATA_PORT: rdata_next = rx_mem[0];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= rdata_next;
    end
  end

  // Level request: holds until software or the vector clears the flag
  assign O_IRQ = buf_mode ? ((en_view[spfdp_pkg::EN_RX_COMPLETE] && flag_view[7])
      || (en_view[spfdp_pkg::EN_TX_COMPLETE] && flag_view[6])
      || (en_view[spfdp_pkg::EN_TX_EMPTY] && flag_view[5])
      || (en_view[spfdp_pkg::EN_SLAVE_SELECT] && flag_view[4]))
    : (en_reg[spfdp_pkg::EN_SINGLE] && flags_reg.xfer);

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  sequence s_flag_read_xfer;
    rd_fl && flags_reg.xfer && !buf_mode;
  endsequence
  sequence s_data_touch;
    dat_acc && !I_SHIFT_DONE && !takeover && !buf_mode;
  endsequence

  chk_xfer_read_clear: assert property (
    s_flag_read_xfer ##1 (!rd_fl && !I_SHIFT_DONE && !takeover && !buf_mode)[*1] ##1 s_data_touch
    |=> !flags_reg.xfer) else $error("Transfer flag survived read then data access");
  chk_done_sets_xfer: assert property (
    (!buf_mode && I_SHIFT_DONE && !$past(wr_cfg)) |=> flag_view[7] || buf_mode)
    else $error("Finished byte did not set transfer flag");
  chk_collision_set: assert property (
    (!buf_mode && wr_dat && I_SHIFT_BUSY && !wr_cfg) |=> flags_reg.collision && !O_SHIFT_LOAD)
    else $error("Busy write did not flag collision");
  chk_empty_cleared: assert property (
    (buf_mode && wr_dat && !wr_cfg) |=> !flags_reg.tx_empty)
    else $error("Data write left transmit-empty set");
  chk_nonbuf_zeros: assert property (
    !buf_mode |-> (flag_view[5:0] == 6'h00) && (en_view[7:1] == 7'h00))
    else $error("Buffered-only bits visible in non-buffered mode");
  chk_rx_flag_level: assert property (
    (buf_mode && I_SHIFT_DONE && !wr_cfg) |=> flag_view[7])
    else $error("Received byte left receive-complete clear");
  chk_rx_clear_write: assert property (
    (rx_wr1c && !I_SHIFT_DONE) |=> !flag_view[7])
    else $error("Write-one left receive-complete set");
  chk_overrun_hold: assert property (
    (flags_reg.rx_overrun && buf_mode && !rd_dat && !wr_cfg) |=> flags_reg.rx_overrun)
    else $error("Overrun dropped without a data read");
  chk_ss_takeover: assert property (
    (buf_mode && takeover && !wr_cfg) |=> flags_reg.slave_select && !O_MASTER)
    else $error("Takeover did not set flag and leave master");
  chk_irq_single: assert property (
    (!buf_mode && en_reg[0] && flags_reg.xfer) |-> O_IRQ)
    else $error("Single enable did not raise interrupt");
  chk_tx_complete_set: assert property (
    (buf_mode && I_SHIFT_DONE && !tx_valid_reg && !wr_dat && !wr_cfg) |=> flags_reg.tx_complete)
    else $error("Transfer-complete not set on idle shifter");
  chk_rdata_pulse: assert property (
    (!I_READ) |=> (O_RDATA == 8'h00)) else $error("Read data outside read answer");
endmodule // spfdp_core

// *** verif/spfdp_shift_model.sv ***
// Far-side shifter: one byte per load or kick, busy from the cycle after
module spfdp_shift_model #(
  parameter int LEN = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Requests
  input wire logic i_load,
  input wire logic i_kick,
  input wire logic [7:0] i_rx_byte,
  // Answers
  output logic o_busy,
  output logic o_start,
  output logic o_done,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic [7:0] rb;
  // Outside done the received lines show the inverse, never a stale byte
  assign o_rdata = o_done ? rb : ~rb;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= 0;
      o_busy <= 1'b0;
      o_start <= 1'b0;
      o_done <= 1'b0;
      rb <= 8'h00;
    end else begin
      o_start <= 1'b0;
      o_done <= 1'b0;
      if ((i_load || i_kick) && cnt == 0) begin
        cnt <= LEN;
        o_busy <= 1'b1;
        o_start <= 1'b1;
        rb <= i_rx_byte;
      end else if (cnt == 1) begin
        cnt <= 0;
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // spfdp_shift_model

// *** verif/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CFG = 8'h04;
  localparam logic [7:0] EN = 8'h08;
  localparam logic [7:0] FL = 8'h0c;
  localparam logic [7:0] DT = 8'h10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ack = 1'b0;
  logic ss_n = 1'b1;
  logic kick = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] rdata, sdata, srdata, t, b0, b1, b2;
  logic irq, sload, sbusy, sstart, sdone, master;
  logic pend = 1'b0;
  logic [31:0] lfsr_state = 32'hef4f35f9;
  logic [15:0] rq[$];
  logic [7:0] lq[$];
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  spfdp_core spfdp_core_i (.I_CLOCK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WRITE(wr_en), .I_READ(rd_en), .O_RDATA(rdata), .O_IRQ(irq), .I_IRQ_ACK(ack),
    .I_SS_N(ss_n), .O_SHIFT_LOAD(sload), .O_SHIFT_DATA(sdata), .I_SHIFT_BUSY(sbusy),
    .I_SHIFT_START(sstart), .I_SHIFT_DONE(sdone), .I_SHIFT_RDATA(srdata), .O_MASTER(master));
  spfdp_shift_model spfdp_shift_model_i (.i_clk(clk), .i_rst(rst), .i_load(sload),
    .i_kick(kick), .i_rx_byte(rx_byte), .o_busy(sbusy), .o_start(sstart), .o_done(sdone),
    .o_rdata(srdata));

  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic void nxt(output logic [7:0] v);
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    v = lfsr_state[7:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Expected value and mask are queued; the monitor compares the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    rq.push_back({e, m});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    #1;
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic xfer_wait;
    int n;
    n = 0;
    while (sdone !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) chk(8'h00, 8'hff);
    repeat (2) @(posedge clk);
  endtask
  task automatic tx(input logic [7:0] d, output logic [7:0] v);
    nxt(v);
    @(posedge clk);
    rx_byte <= v;
    lq.push_back(d);
    wr(DT, d);
  endtask
  task automatic kick_rx(output logic [7:0] v);
    nxt(v);
    @(posedge clk);
    rx_byte <= v;
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    xfer_wait();
  endtask
  task automatic pulse_ack;
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
  endtask
  task automatic ss_low(input logic [7:0] cfg, input logic m);
    wr(CFG, cfg);
    ss_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({7'h00, master}, {7'h00, m});
  endtask

  always @(posedge clk) begin : mon
    logic [15:0] e;
    if (pend) begin
      e = rq.pop_front();
      chk(rdata & e[7:0], e[15:8]);
    end
    if (sload === 1'b1) chk(sdata, lq.pop_front());
    pend <= rd_en;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(FL, 8'h00, 8'hff);
    rd(DT, 8'h00, 8'hff);
    rd(EN, 8'h00, 8'hff);
    rd(8'h3c, 8'h00, 8'hff);
    wr(EN, 8'hf1);
    rd(EN, 8'h01, 8'hff);
    // Non-buffered: second write lands while shifting
    nxt(t);
    tx(t, b0);
    repeat (4) @(posedge clk);
    wr(DT, 8'h5a);
    xfer_wait();
    rd(FL, 8'hc0, 8'hff);
    irq_is(1'b1);
    rd(DT, b0, 8'hff);
    rd(FL, 8'h00, 8'hff);
    irq_is(1'b0);
    nxt(t);
    tx(t, b0);
    xfer_wait();
    pulse_ack();
    rd(FL, 8'h00, 8'h80);
    ss_low(8'h22, 1'b0);
    rd(FL, 8'h80, 8'h80);
    ss_n <= 1'b1;
    pulse_ack();
    // Buffered mode; overrun bit always written as zero
    wr(CFG, 8'ha2);
    wr(FL, 8'hd0);
    wr(EN, 8'h80);
    irq_is(1'b0);
    nxt(t);
    tx(t, b0);
    repeat (4) @(posedge clk);
    nxt(t);
    nxt(b1);
    rx_byte <= b1;
    lq.push_back(t);
    wr(DT, t);
    rd(FL, 8'h00, 8'h20);
    xfer_wait();
    xfer_wait();
    rd(FL, 8'he0, 8'he1);
    irq_is(1'b1);
    wr(FL, 8'h40);
    rd(FL, 8'ha0, 8'he0);
    rd(DT, b0, 8'hff);
    rd(DT, b1, 8'hff);
    rd(FL, 8'h00, 8'h80);
    irq_is(1'b0);
    kick_rx(b0);
    rd(FL, 8'h80, 8'h80);
    wr(FL, 8'h80);
    rd(FL, 8'h00, 8'h80);
    kick_rx(b0);
    kick_rx(b1);
    kick_rx(b2);
    kick_rx(t);
    rd(FL, 8'h81, 8'h81);
    rd(DT, b0, 8'hff);
    rd(FL, 8'h00, 8'h01);
    rd(DT, b1, 8'hff);
    rd(FL, 8'h00, 8'h80);
    // Takeover in buffered mode, then with select ignored
    wr(EN, 8'h10);
    ss_low(8'ha2, 1'b0);
    rd(FL, 8'h10, 8'h10);
    irq_is(1'b1);
    ss_n <= 1'b1;
    wr(FL, 8'h10);
    rd(FL, 8'h00, 8'h10);
    irq_is(1'b0);
    ss_low(8'ha6, 1'b1);
    rd(FL, 8'h00, 8'h10);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'(lq.size()), 8'h00);
    tally_and_finish();
  end
endmodule // tb
